// file: pkg/i2c_slave_consts.vh
// register offsets, field positions, reset values and bus codes of the i2c slave status block
`ifndef I2C_SLAVE_CONSTS_VH
`define I2C_SLAVE_CONSTS_VH

// register byte addresses on the apb bus
`define OFF_TX_BYTE 8'hEC
`define OFF_CONTROL 8'hF0
`define OFF_OWN_ADDR 8'hF4
`define OFF_STATUS 8'hF8

// slave_event_status bit positions
`define ST_HIGH_SPEED 7
`define ST_ACTIVE 6
`define ST_IRQ 5
`define ST_NACK 4
`define ST_START 3
`define ST_STOP 2
`define ST_WR 1
`define ST_RD 0

// slave_port_control bit positions
`define CN_PULLUP 5
`define CN_PINSEL 4
`define CN_TIMEOUT 3
`define CN_PRELOAD_DIS 2
`define CN_ENABLE 1
`define CN_BUSY 0

// reset values
`define CONTROL_RESET 6'h05
`define OWN_ADDR_RESET 7'h00
`define TX_BYTE_RESET 8'h00

// high-speed master code is 00001xxx
`define HS_CODE_TOP 5'h01

// bit counter value of the acknowledge bit
`define ACK_BIT_CNT 4'h8
`define LAST_DATA_CNT 4'h7
// loaded at START so that the START's own scl fall wraps it to zero
`define BIT_CNT_START 4'hF

`endif

// file: hdl/pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter W = 2
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);

genvar i;
generate
	for (i = 0; i < W; i = i + 1) begin : g_bit
		reg meta_q;
		reg s2_q;
		reg s3_q;
		reg out_q;
		// idle bus level is high, so all stages reset to one
		always @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				meta_q <= 1'b1;
				s2_q <= 1'b1;
				s3_q <= 1'b1;
				out_q <= 1'b1;
			end else if (ce) begin
				meta_q <= din[i];
				s2_q <= meta_q;
				s3_q <= s2_q;
				// a change counts only once stages two and three agree
				if (s2_q == s3_q) begin
					out_q <= s3_q;
				end
			end
		end
		assign dout[i] = out_q;
	end
endgenerate

endmodule // pin_sync

`default_nettype wire

// file: hdl/i2c_slave_status_control.v
// i2c slave status flags, control register, bit engine and apb register slave
//
// Operation
// - high_speed_flag sets on high-speed master code, clears on STOP
// - bus-active flag sets when incoming address matches own address
// - bus-active flag clears when transfer ends by STOP or NACK
// - slave_irq_flag sets on read request, write request or STOP when last address matched own address
// - slave_irq_flag also sets when bus-active flag falls
// - interrupt requested while flag set; flag clears when a status write of 0 to it also leaves read and write clear
// - NACK flag sets on any NACK while bus active; software clears it
// - NACK flag also sets when slave NACKs a matching address
// - start flag sets only on START followed by matching address
// - stop flag sets on STOP when last address matched own address
// - ninth fall of received data byte sets write flag unless DMA takes writes
// - ninth fall of matching address with write direction sets write flag
// - ninth fall sets read flag on master ACK without DMA, or master NACK
// - ninth fall of matching address with read direction sets read flag
// - read or write flag also sets interrupt flag; software clears both
// - control holds pullup, pin select, timeout, preload disable, enable, busy
// - busy set NACKs all bytes; busy clear acknowledges the master
// - SCL is held low after each acknowledge-bit falling edge of an addressed transfer, while the interrupt flag stays set
// - preload disable clear: transmit byte taken at eighth address clock
`include "i2c_slave_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module i2c_slave_status_control (
	input wire ref_clk,
	input wire arst_n,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire dma_wr_sel,
	input wire dma_rd_sel,
	output wire slave_irq,
	output wire pullup_enable,
	output wire pin_function_select,
	output wire timeout_enable
);

////////////////////////////////////////////////////////////////////////////////
// register decode

// one-hot select: {tx byte, own address, control, status}
function [3:0] reg_sel;
	input [7:0] a;
	begin
		case (a)
			`OFF_STATUS: reg_sel = 4'h1;
			`OFF_CONTROL: reg_sel = 4'h2;
			`OFF_OWN_ADDR: reg_sel = 4'h4;
			`OFF_TX_BYTE: reg_sel = 4'h8;
			default: reg_sel = 4'h0;
		endcase
	end
endfunction

localparam [4:0] S_IDLE = 5'h01;
localparam [4:0] S_ADDR = 5'h02;
localparam [4:0] S_WRITE = 5'h04;
localparam [4:0] S_READ = 5'h08;
localparam [4:0] S_SKIP = 5'h10;

reg [5:0] ctrl_q;
reg [6:0] own_q;
reg [7:0] txb_q;
reg [31:0] prdata_q;
reg hs_q, act_q, irq_q, nack_q, start_q, stop_q, wr_q, rd_q;
reg [4:0] state_q;
reg [3:0] cnt_q;
reg [7:0] sh_q;
reg [7:0] txs_q;
reg scl_q, sda_q;
reg match_q, dir_q, last_match_q, drv_ack_q, mnack_q, sda_drv_q, stretch_q;

wire [3:0] sel = reg_sel(paddr);
wire wr_acc = psel & penable & pwrite;
wire st_wr = wr_acc & sel[0];
wire busy = ctrl_q[`CN_BUSY];
wire preload_dis = ctrl_q[`CN_PRELOAD_DIS];
wire en = ctrl_q[`CN_ENABLE] & ctrl_q[`CN_PINSEL];

////////////////////////////////////////////////////////////////////////////////
// bus pin sampling and condition detection

wire scl_s;
wire sda_s;

pin_sync #(.W(2)) u_pin_sync (
	.clk(ref_clk),
	.arst_n(arst_n),
	.ce(ce),
	.din({scl_in, sda_in}),
	.dout({scl_s, sda_s})
);

wire scl_rise = scl_s & ~scl_q;
wire scl_fall = ~scl_s & scl_q;
wire start_ev = en & scl_s & scl_q & sda_q & ~sda_s;
wire stop_ev = en & scl_s & scl_q & ~sda_q & sda_s;
wire in_byte = (state_q == S_ADDR) | (state_q == S_WRITE) | (state_q == S_READ);
wire fall8 = in_byte & scl_fall & (cnt_q == `LAST_DATA_CNT);
wire fall9 = in_byte & scl_fall & (cnt_q == `ACK_BIT_CNT);
wire addressed = (state_q == S_ADDR) ? match_q : 1'b1;
wire release_ev = stretch_q & ~irq_q;

wire addr_match = en & (sh_q[7:1] == own_q);

////////////////////////////////////////////////////////////////////////////////
// flag set and clear terms

reg wr_set, rd_set, nack_set, start_set, act_clr_nack;

always @* begin
	wr_set = 1'b0;
	rd_set = 1'b0;
	nack_set = 1'b0;
	start_set = 1'b0;
	act_clr_nack = 1'b0;
	if (fall9) begin
		case (state_q)
			S_ADDR: begin
				if (match_q) begin
					start_set = 1'b1;
					wr_set = ~dir_q;
					rd_set = dir_q;
					nack_set = ~drv_ack_q;
					act_clr_nack = ~drv_ack_q;
				end
			end
			S_WRITE: begin
				wr_set = ~dma_wr_sel;
				nack_set = ~drv_ack_q & act_q;
				act_clr_nack = ~drv_ack_q;
			end
			S_READ: begin
				rd_set = (~mnack_q & ~dma_rd_sel) | mnack_q;
				nack_set = mnack_q & act_q;
				act_clr_nack = mnack_q;
			end
			default: begin
				wr_set = 1'b0;
			end
		endcase
	end
end

wire stop_set = stop_ev & last_match_q;
wire act_set = (state_q == S_ADDR) & fall8 & addr_match;
wire act_clr = stop_ev | act_clr_nack;
wire act_fall = act_q & act_clr & ~act_set;
wire irq_set = rd_set | wr_set | stop_set | act_fall;
wire hs_set = (state_q == S_ADDR) & fall8 & (sh_q[7:3] == `HS_CODE_TOP);

// writing 0 to a bit, or 0 to the irq bit (scl release), clears the event flags
wire clr_rel = st_wr & ~pwdata[`ST_IRQ];
wire rd_d = rd_set | (rd_q & ~(st_wr & ~pwdata[`ST_RD]) & ~clr_rel);
wire wr_d = wr_set | (wr_q & ~(st_wr & ~pwdata[`ST_WR]) & ~clr_rel);

////////////////////////////////////////////////////////////////////////////////
// status flags

always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		hs_q <= 1'b0;
		act_q <= 1'b0;
		irq_q <= 1'b0;
		nack_q <= 1'b0;
		start_q <= 1'b0;
		stop_q <= 1'b0;
		wr_q <= 1'b0;
		rd_q <= 1'b0;
	end else if (ce) begin
		// set on code, clear on stop
		hs_q <= hs_set | (hs_q & ~stop_ev);
		act_q <= act_set | (act_q & ~act_clr);
		// clear on status write of 0 to irq, if rd and wr end clear
		irq_q <= irq_set | (irq_q & ~(clr_rel & ~rd_d & ~wr_d));
		nack_q <= nack_set | (nack_q & ~(st_wr & ~pwdata[`ST_NACK]) & ~clr_rel);
		start_q <= start_set | (start_q & ~(st_wr & ~pwdata[`ST_START]) & ~clr_rel);
		stop_q <= stop_set | (stop_q & ~(st_wr & ~pwdata[`ST_STOP]) & ~clr_rel);
		wr_q <= wr_d;
		rd_q <= rd_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// bit engine

always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		state_q <= S_IDLE;
		cnt_q <= 4'h0;
		sh_q <= 8'h00;
		txs_q <= 8'h00;
		scl_q <= 1'b1;
		sda_q <= 1'b1;
		match_q <= 1'b0;
		dir_q <= 1'b0;
		last_match_q <= 1'b0;
		drv_ack_q <= 1'b0;
		mnack_q <= 1'b0;
		sda_drv_q <= 1'b0;
		stretch_q <= 1'b0;
	end else if (ce) begin
		scl_q <= scl_s;
		sda_q <= sda_s;
		stretch_q <= (fall9 & addressed) | (stretch_q & irq_q);
		if (!en || stop_ev) begin
			state_q <= S_IDLE;
			sda_drv_q <= 1'b0;
			stretch_q <= 1'b0;
			if (stop_ev) begin
				last_match_q <= 1'b0;
			end
		end else if (start_ev) begin
			state_q <= S_ADDR;
			cnt_q <= `BIT_CNT_START;
			match_q <= 1'b0;
			sda_drv_q <= 1'b0;
			stretch_q <= 1'b0;
		end else begin
			if (scl_rise && in_byte) begin
				if (cnt_q == `ACK_BIT_CNT) begin
					mnack_q <= sda_s;
				end else begin
					sh_q <= {sh_q[6:0], sda_s};
				end
			end
			if (scl_fall && in_byte) begin
				cnt_q <= (cnt_q == `ACK_BIT_CNT) ? 4'h0 : cnt_q + 4'h1;
			end
			case (state_q)
				S_ADDR: begin
					if (fall8) begin
						match_q <= addr_match;
						last_match_q <= addr_match;
						dir_q <= sh_q[0];
						drv_ack_q <= addr_match & ~busy;
						sda_drv_q <= addr_match & ~busy;
						if (addr_match && sh_q[0] && !preload_dis) begin
							txs_q <= txb_q;
						end
					end else if (fall9) begin
						sda_drv_q <= 1'b0;
						if (match_q && drv_ack_q) begin
							state_q <= dir_q ? S_READ : S_WRITE;
						end else begin
							state_q <= S_SKIP;
						end
					end
				end
				S_WRITE: begin
					if (fall8) begin
						drv_ack_q <= ~busy;
						sda_drv_q <= ~busy;
					end else if (fall9) begin
						sda_drv_q <= 1'b0;
						state_q <= drv_ack_q ? S_WRITE : S_SKIP;
					end
				end
				S_READ: begin
					if (release_ev) begin
						if (preload_dis) begin
							txs_q <= txb_q;
							sda_drv_q <= ~txb_q[7];
						end else begin
							sda_drv_q <= ~txs_q[7];
						end
					end else if (fall8 || fall9) begin
						sda_drv_q <= 1'b0;
						if (fall9) begin
							state_q <= mnack_q ? S_SKIP : S_READ;
							if (!preload_dis) begin
								txs_q <= txb_q;
							end
						end
					end else if (scl_fall) begin
						txs_q <= {txs_q[6:0], 1'b0};
						sda_drv_q <= ~txs_q[6];
					end
				end
				default: begin
					sda_drv_q <= 1'b0;
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// apb registers

always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		ctrl_q <= `CONTROL_RESET;
		own_q <= `OWN_ADDR_RESET;
		txb_q <= `TX_BYTE_RESET;
		prdata_q <= 32'h0000_0000;
	end else if (ce) begin
		if (wr_acc && sel[1]) begin
			ctrl_q <= pwdata[5:0];
		end
		if (wr_acc && sel[2]) begin
			own_q <= pwdata[6:0];
		end
		if (wr_acc && sel[3]) begin
			txb_q <= pwdata[7:0];
		end
		// read data captured in the setup phase
		if (psel && !penable) begin
			case (1'b1)
				sel[0]: prdata_q <= {24'h00_0000, hs_q, act_q, irq_q, nack_q, start_q, stop_q, wr_q, rd_q};
				sel[1]: prdata_q <= {26'h000_0000, ctrl_q};
				sel[2]: prdata_q <= {25'h000_0000, own_q};
				sel[3]: prdata_q <= {24'h00_0000, txb_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end
end

assign prdata = prdata_q;
assign pready = 1'b1;
assign pslverr = psel & penable & (sel == 4'h0);

////////////////////////////////////////////////////////////////////////////////
// outputs

assign slave_irq = irq_q;
assign pullup_enable = ctrl_q[`CN_PULLUP];
assign pin_function_select = ctrl_q[`CN_PINSEL];
assign timeout_enable = ctrl_q[`CN_TIMEOUT];
assign scl_out = 1'b0;
assign scl_oe = stretch_q;
assign sda_out = 1'b0;
assign sda_oe = sda_drv_q;

endmodule // i2c_slave_status_control

`default_nettype wire

// file: verification/i2c_slave_status_control_monitor.sv
// port-level checks on the i2c slave status block
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_status_control_monitor (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic slave_irq,
	input wire logic pullup_enable,
	input wire logic pin_function_select,
	input wire logic timeout_enable
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire logic acc = psel && penable;
	wire logic st_wr = acc && pwrite && paddr == 8'hF8;
	wire logic mapped = paddr == 8'hEC || paddr == 8'hF0 || paddr == 8'hF4 || paddr == 8'hF8;
	a_reset_pins: assert property (!$past(arst_n) |->
		!pullup_enable && !pin_function_select && !timeout_enable)
		else $error("control pins not clear after reset");
	a_ctrl_pins: assert property (acc && pwrite && paddr == 8'hF0 |=>
		pullup_enable == $past(pwdata[5]) && pin_function_select == $past(pwdata[4])
		&& timeout_enable == $past(pwdata[3]))
		else $error("control pins do not follow write");
	a_irq_fall_cause: assert property ($fell(slave_irq) |-> $past(st_wr))
		else $error("interrupt cleared without status write");
	a_stretch_hold: assert property (scl_oe && slave_irq && !st_wr |=> scl_oe)
		else $error("clock stretch released early");
	a_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_in))
		else $error("stretch started with clock high");
	a_enable_gate: assert property (sda_oe || scl_oe |-> pin_function_select)
		else $error("lines driven while disabled");
	a_open_drain: assert property (!scl_out && !sda_out)
		else $error("line driven high");
	a_sda_change_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
		else $error("data line changed while clock high");
	a_err_map: assert property (acc |-> pslverr == !mapped)
		else $error("error response wrong");
endmodule // i2c_slave_status_control_monitor
bind i2c_slave_status_control i2c_slave_status_control_monitor u_mon (.ref_clk(ref_clk), .arst_n(arst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
	.slave_irq(slave_irq), .pullup_enable(pullup_enable), .pin_function_select(pin_function_select),
	.timeout_enable(timeout_enable));
`default_nettype wire

// file: verification/i2c_master_model.sv
// behavioural i2c bus master on open-drain lines
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model #(
	parameter int HALF = 100
) (
	input wire logic scl,
	input wire logic sda,
	output logic scl_lo,
	output logic sda_lo
);
	initial begin
		scl_lo = 1'h0;
		sda_lo = 1'h0;
	end
	task automatic clk_bit(input logic b, output logic s);
		#(HALF / 2);
		sda_lo = !b;
		#(HALF / 2);
		scl_lo = 1'h0;
		wait (scl === 1'h1);
		#HALF;
		s = sda;
		scl_lo = 1'h1;
	endtask
	task automatic start();
		sda_lo = 1'h1;
		#HALF;
		scl_lo = 1'h1;
	endtask
	task automatic stop();
		// sda low while scl low, release scl, then sda rises with scl high
		sda_lo = 1'h1;
		#HALF;
		scl_lo = 1'h0;
		wait (scl === 1'h1);
		#HALF;
		sda_lo = 1'h0;
		#HALF;
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
		clk_bit(1'h1, s);
		ack = !s;
	endtask
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(1'h1, d[i]);
		clk_bit(!ack, s);
	endtask
endmodule // i2c_master_model
`default_nettype wire

// file: verification/i2c_slave_status_control_tb.sv
// self-checking bench for the i2c slave status block
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_status_control_tb;
	logic ref_clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, dma_wr_sel = 1'h0;
	logic dma_rd_sel = 1'h0;
	logic [7:0] paddr = 8'h00, b;
	logic [31:0] pwdata = 32'h0, rd;
	logic perr, ack;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, slave_irq, scl_lo, sda_lo;
	wire logic scl_in = !(scl_lo || scl_oe);
	wire logic sda_in = !(sda_lo || sda_oe);
	always #4 ref_clk = !ref_clk;
	i2c_slave_status_control u_i2c_slave_status_control (.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'h1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .dma_wr_sel(dma_wr_sel), .dma_rd_sel(dma_rd_sel),
		.slave_irq(slave_irq), .pullup_enable(), .pin_function_select(), .timeout_enable());
	i2c_master_model u_i2c_master_model (.scl(scl_in), .sda(sda_in), .scl_lo(scl_lo), .sda_lo(sda_lo));
	////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'h1;
		@(posedge ref_clk);
		while (pready !== 1'h1) @(posedge ref_clk);
		rd = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic st(input logic [7:0] exp);
		int n;
		n = 0;
		while (slave_irq !== 1'h1 && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (4) @(posedge ref_clk);
		apb(1'h0, 8'hF8, 8'h00);
		chk(rd, {24'h0, exp});
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		apb(1'h0, 8'hF0, 8'h00);
		chk(rd, 32'h05);
		apb(1'h0, 8'h10, 8'h00);
		chk({rd[30:0], perr}, 32'h1);
		apb(1'h1, 8'hF0, 8'hFF);
		apb(1'h0, 8'hF0, 8'h00);
		chk(rd, 32'h3F);
		apb(1'h1, 8'hF0, 8'h10);
		apb(1'h1, 8'hF0, 8'h12);
		apb(1'h1, 8'hF4, 8'h2A);
		apb(1'h1, 8'hEC, 8'hA5);
		$display("test regs done");
	endtask
	task automatic t_write();
		u_i2c_master_model.start();
		u_i2c_master_model.wr_byte(8'h54, ack);
		chk({31'h0, ack}, 32'h1);
		st(8'h6A);
		apb(1'h1, 8'hF8, 8'h00);
		st(8'h40);
		u_i2c_master_model.wr_byte(8'h55, ack);
		st(8'h62);
		apb(1'h1, 8'hF8, 8'h00);
		dma_wr_sel <= 1'h1;
		u_i2c_master_model.wr_byte(8'hAA, ack);
		st(8'h40);
		dma_wr_sel <= 1'h0;
		u_i2c_master_model.stop();
		st(8'h24);
		apb(1'h1, 8'hF8, 8'h00);
		$display("test write done");
	endtask
	task automatic t_read();
		u_i2c_master_model.start();
		u_i2c_master_model.wr_byte(8'h55, ack);
		st(8'h69);
		apb(1'h1, 8'hF8, 8'h00);
		u_i2c_master_model.rd_byte(1'h0, b);
		chk({24'h0, b}, 32'hA5);
		st(8'h31);
		apb(1'h1, 8'hF8, 8'h00);
		u_i2c_master_model.stop();
		st(8'h24);
		apb(1'h1, 8'hF8, 8'h00);
		$display("test read done");
	endtask
	task automatic t_late();
		apb(1'h1, 8'hF0, 8'h16);
		u_i2c_master_model.start();
		u_i2c_master_model.wr_byte(8'h55, ack);
		st(8'h69);
		apb(1'h1, 8'hEC, 8'hC3);
		apb(1'h1, 8'hF8, 8'h00);
		u_i2c_master_model.rd_byte(1'h1, b);
		chk({24'h0, b}, 32'hC3);
		st(8'h61);
		dma_rd_sel <= 1'h1;
		apb(1'h1, 8'hF8, 8'h00);
		u_i2c_master_model.rd_byte(1'h1, b);
		chk({24'h0, b}, 32'hC3);
		st(8'h40);
		u_i2c_master_model.rd_byte(1'h0, b);
		chk({24'h0, b}, 32'hC3);
		st(8'h31);
		dma_rd_sel <= 1'h0;
		apb(1'h1, 8'hF8, 8'h00);
		u_i2c_master_model.stop();
		st(8'h24);
		apb(1'h1, 8'hF8, 8'h00);
		apb(1'h1, 8'hF0, 8'h12);
		$display("test late load done");
	endtask
	task automatic t_busy();
		apb(1'h1, 8'hF0, 8'h13);
		u_i2c_master_model.start();
		u_i2c_master_model.wr_byte(8'h54, ack);
		chk({31'h0, ack}, 32'h0);
		st(8'h3A);
		apb(1'h1, 8'hF8, 8'h00);
		u_i2c_master_model.stop();
		st(8'h24);
		apb(1'h1, 8'hF8, 8'h00);
		apb(1'h1, 8'hF0, 8'h12);
		$display("test busy done");
	endtask
	task automatic t_other();
		u_i2c_master_model.start();
		u_i2c_master_model.wr_byte(8'h56, ack);
		chk({31'h0, ack}, 32'h0);
		u_i2c_master_model.stop();
		st(8'h00);
		u_i2c_master_model.start();
		u_i2c_master_model.wr_byte(8'h08, ack);
		st(8'h80);
		u_i2c_master_model.stop();
		st(8'h00);
		$display("test other done");
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'h1;
		repeat (10) @(posedge ref_clk);
		t_regs();
		t_write();
		t_read();
		t_late();
		t_busy();
		t_other();
		end_of_test();
	end
endmodule // i2c_slave_status_control_tb
`default_nettype wire
